// *** hdl/mps_pkg.sv ***
// shared constants and types of the motor mode and protection supervisor
package mps_pkg;

  // ==========================================================================
  // system modes and run states
  typedef enum logic [2:0] {
    MD_INACTIVE = 3'h1,
    MD_ACTIVE = 3'h2,
    MD_ERROR = 3'h4
  } mps_mode_t;

  typedef enum logic [4:0] {
    RS_STOP = 5'h01,
    RS_OPEN_LOOP = 5'h02,
    RS_SWITCH_UP = 5'h04,
    RS_OBSERVER = 5'h08,
    RS_SWITCH_DOWN = 5'h10
  } mps_run_t;

  // ==========================================================================
  // fault flag layout
  localparam int FLT_W = 6;
  localparam int FLT_OVERCURRENT = 0;
  localparam int FLT_OVERVOLTAGE = 1;
  localparam int FLT_UNDERVOLTAGE = 2;
  localparam int FLT_OVERSPEED = 3;
  localparam int FLT_STALL = 4;
  localparam int FLT_HW_ESTOP = 5;
  localparam logic [FLT_W-1:0] FLT_RESET = 6'h00;

  // ==========================================================================
  // protection limits (volts, rpm) and overcurrent scaling
  localparam int OV_LIMIT_V = 450;
  localparam int UV_LIMIT_V = 100;
  localparam int SPEED_LIMIT_RPM = 4200;
  localparam int OPEN_LOOP_LIMIT_RPM = 600;
  // limit = rated rms setting * num >> shift; default num is about sqrt(2)
  localparam int OC_SCALE_NUM = 362;
  localparam int OC_SCALE_SHIFT = 8;

  // ==========================================================================
  // pwm pin count
  localparam int PWM_W = 6;
  localparam logic [PWM_W-1:0] PWM_RESET = 6'h00;

endpackage

// *** hdl/mps_supervisor.sv ***
// motor mode, run sequence and protection supervisor with pwm gating
`timescale 1ns/10ps

// Overview of operation
// RQ1: system mode is always exactly one of inactive, active or error.
// RQ2: inactive, active, reset come from user; error only from own fault checks.
// RQ3: run state advances only in active mode; otherwise it stays stopped.
// RQ4: after reset the run state is stop with no drive applied.
// RQ5: open loop drives the motor from 0 rpm up to the adjustable threshold.
// RQ6: accelerating switch hands data to observer, then enters observer state.
// RQ7: decelerating switch hands data back, then returns to open loop.
// RQ8: observer state drives sensorless vector control above the lower limit.
// RQ9: hardware emergency stop puts all pwm pins into high impedance at once; here on the third clock edge after the pin falls.
// RQ10: each control tick, every phase current checked against overcurrent limit.
// RQ11: overcurrent limit is derived from the rated motor current setting.
// RQ12: each control tick, bus voltage above 450 V stops the motor.
// RQ13: each control tick, bus voltage below 100 V stops the motor.
// RQ14: each control tick, speed above 4200 rpm stops the motor.
// RQ15: stall stops the motor only in observer state with stall check enabled.
// RQ16: any emergency stop forces error, run stop, pwm off until reset.
// RQ17: reset event in error clears fault flags and returns to inactive; here only when no fault event arrives in the same cycle.
module mps_supervisor
  import mps_pkg::*;
#(
  parameter int CUR_W = 16,
  parameter int VOLT_W = 16,
  parameter int SPD_W = 16,
  parameter int THRESH_RPM = OPEN_LOOP_LIMIT_RPM
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_active,
  input wire logic cmd_inactive,
  input wire logic cmd_reset,
  input wire logic ctrl_tick,
  input wire logic signed [CUR_W-1:0] phase_u_ma,
  input wire logic signed [CUR_W-1:0] phase_v_ma,
  input wire logic signed [CUR_W-1:0] phase_w_ma,
  input wire logic [CUR_W-1:0] rated_motor_current_setting,
  input wire logic [VOLT_W-1:0] bus_volts,
  input wire logic signed [SPD_W-1:0] speed_rpm,
  input wire logic signed [SPD_W-1:0] speed_cmd_rpm,
  input wire logic handover_done,
  input wire logic stall_enable,
  input wire logic stall_seen,
  input wire logic estop_hw_b,
  input wire logic [PWM_W-1:0] pwm_in,
  output mps_mode_t mode_q,
  output mps_run_t run_q,
  output logic [FLT_W-1:0] fault_q,
  output logic observer_sel_q,
  output logic handover_req_q,
  output logic [PWM_W-1:0] pwm_out_q,
  output logic [PWM_W-1:0] pwm_oe_q
);

  localparam logic [SPD_W-1:0] THRESH = SPD_W'(THRESH_RPM);
  localparam logic [SPD_W-1:0] SPD_LIM = SPD_W'(SPEED_LIMIT_RPM);
  localparam logic [VOLT_W-1:0] OV_LIM = VOLT_W'(OV_LIMIT_V);
  localparam logic [VOLT_W-1:0] UV_LIM = VOLT_W'(UV_LIMIT_V);
  localparam logic [CUR_W-1:0] OC_NUM = CUR_W'(OC_SCALE_NUM);
  localparam int PROD_W = 2 * CUR_W;

  function automatic logic [CUR_W-1:0] mag(input logic signed [CUR_W-1:0] v);
    mag = v[CUR_W-1] ? CUR_W'(-v) : v;
  endfunction

  // ==========================================================================
  // emergency stop pin synchroniser
  logic estop_m1_q;
  logic estop_s_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      estop_m1_q <= 1'b0;
      estop_s_q <= 1'b0;
    end else begin
      estop_m1_q <= ~estop_hw_b;
      estop_s_q <= estop_m1_q;
    end
  end

  // ==========================================================================
  // protection checks
  logic [PROD_W-1:0] oc_prod;
  logic [PROD_W-1:0] oc_limit;
  logic [FLT_W-1:0] flt_evt;
  logic any_evt;
  logic [SPD_W-1:0] spd_mag;
  logic [SPD_W-1:0] cmd_mag;

  always_comb begin
    oc_prod = PROD_W'(rated_motor_current_setting) * PROD_W'(OC_NUM); // [RQ11]
    oc_limit = oc_prod >> OC_SCALE_SHIFT; // [RQ11]
    spd_mag = mag(speed_rpm);
    cmd_mag = mag(speed_cmd_rpm);
    flt_evt = FLT_RESET;
    if (ctrl_tick) begin
      flt_evt[FLT_OVERCURRENT] = ({{CUR_W{1'b0}}, mag(phase_u_ma)} > oc_limit) ||
                                 ({{CUR_W{1'b0}}, mag(phase_v_ma)} > oc_limit) ||
                                 ({{CUR_W{1'b0}}, mag(phase_w_ma)} > oc_limit); // [RQ10]
      flt_evt[FLT_OVERVOLTAGE] = bus_volts > OV_LIM; // [RQ12]
      flt_evt[FLT_UNDERVOLTAGE] = bus_volts < UV_LIM; // [RQ13]
      flt_evt[FLT_OVERSPEED] = spd_mag > SPD_LIM; // [RQ14]
      flt_evt[FLT_STALL] = stall_seen && stall_enable && (run_q == RS_OBSERVER); // [RQ15]
    end
    // a supply glitch while stopped still matters, so all checks but stall run in every mode
    flt_evt[FLT_HW_ESTOP] = estop_s_q; // [RQ9]
    any_evt = |flt_evt;
  end

  // ==========================================================================
  // mode and run sequencing
  mps_mode_t mode_d;
  mps_run_t run_d;
  logic [FLT_W-1:0] fault_d;

  always_comb begin
    mode_d = mode_q;
    run_d = run_q;
    fault_d = fault_q | flt_evt;
    case (mode_q)
      MD_INACTIVE: begin
        if (cmd_active) begin
          mode_d = MD_ACTIVE; // [RQ2]
        end
      end
      MD_ACTIVE: begin
        if (cmd_inactive) begin
          mode_d = MD_INACTIVE; // [RQ2]
        end
      end
      MD_ERROR: begin
        // a fault arriving with the reset keeps the error and its flag
        if (cmd_reset && !any_evt) begin
          mode_d = MD_INACTIVE; // [RQ17]
          fault_d = FLT_RESET; // [RQ17]
        end
      end
      default: begin
        mode_d = MD_ERROR;
      end
    endcase
    if (any_evt) begin
      mode_d = MD_ERROR; // [RQ2] [RQ16]
    end
    if (mode_d != MD_ACTIVE) begin
      run_d = RS_STOP; // [RQ3] [RQ16]
    end else begin
      case (run_q)
        RS_STOP: begin
          run_d = RS_OPEN_LOOP; // [RQ5]
        end
        RS_OPEN_LOOP: begin
          if (cmd_mag > THRESH) begin
            run_d = RS_SWITCH_UP;
          end
        end
        RS_SWITCH_UP: begin
          if (handover_done) begin
            run_d = RS_OBSERVER; // [RQ6]
          end
        end
        RS_OBSERVER: begin
          // threshold doubles as the observer's lower speed limit
          if (cmd_mag <= THRESH) begin
            run_d = RS_SWITCH_DOWN; // [RQ8]
          end
        end
        RS_SWITCH_DOWN: begin
          if (handover_done) begin
            run_d = RS_OPEN_LOOP; // [RQ7]
          end
        end
        default: begin
          run_d = RS_STOP;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MD_INACTIVE; // [RQ1]
      run_q <= RS_STOP; // [RQ4]
      fault_q <= FLT_RESET;
    end else begin
      mode_q <= mode_d;
      run_q <= run_d;
      fault_q <= fault_d;
    end
  end

  // ==========================================================================
  // pwm gating and algorithm selection
  logic [PWM_W-1:0] pwm_oe_d;
  logic observer_sel_d;
  logic handover_req_d;

  always_comb begin
    // the pin path adds two sync stages; the inverter gate has its own hard trip
    pwm_oe_d = {PWM_W{(mode_d == MD_ACTIVE) && (run_d != RS_STOP) && !estop_s_q}}; // [RQ9] [RQ16]
    observer_sel_d = (run_d == RS_OBSERVER); // [RQ8]
    handover_req_d = (run_d == RS_SWITCH_UP) || (run_d == RS_SWITCH_DOWN); // [RQ6] [RQ7]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_oe_q <= PWM_RESET;
      pwm_out_q <= PWM_RESET;
      observer_sel_q <= 1'b0;
      handover_req_q <= 1'b0;
    end else begin
      pwm_oe_q <= pwm_oe_d;
      pwm_out_q <= pwm_in;
      observer_sel_q <= observer_sel_d;
      handover_req_q <= handover_req_d;
    end
  end

  // ==========================================================================
  // checks
  mode_onehot_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ1]
    $onehot(mode_q)) else $error("system mode not one-hot");

  error_source_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ2]
    (mode_q == MD_ERROR) && !$past(mode_q == MD_ERROR) |-> $past(any_evt))
    else $error("error mode entered without a fault");

  idle_run_stop_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ3]
    (mode_q != MD_ACTIVE) |-> (run_q == RS_STOP) && (pwm_oe_q == PWM_RESET))
    else $error("run state or drive outside active mode");

  hw_estop_off_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ9]
    estop_s_q |=> (pwm_oe_q == PWM_RESET) && (mode_q == MD_ERROR) && fault_q[FLT_HW_ESTOP])
    else $error("pwm still driven after hardware stop");

  overcurrent_trip_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ10]
    ctrl_tick && ({{CUR_W{1'b0}}, mag(phase_v_ma)} > oc_limit)
    |=> fault_q[FLT_OVERCURRENT] && (mode_q == MD_ERROR) && (run_q == RS_STOP))
    else $error("overcurrent not tripped");

  bus_volt_trip_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ12] [RQ13]
    ctrl_tick && ((bus_volts > OV_LIM) || (bus_volts < UV_LIM))
    |=> (mode_q == MD_ERROR) && (fault_q[FLT_OVERVOLTAGE] || fault_q[FLT_UNDERVOLTAGE]))
    else $error("bus voltage fault not tripped");

  stall_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ15]
    $rose(fault_q[FLT_STALL]) |-> $past(stall_enable && (run_q == RS_OBSERVER)))
    else $error("stall flagged outside enabled observer state");

  switch_up_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ6]
    (run_q == RS_SWITCH_UP) && handover_done && !any_evt && !cmd_inactive
    |=> (run_q == RS_OBSERVER) && observer_sel_q && !handover_req_q)
    else $error("observer not entered");

  switch_down_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ7]
    (run_q == RS_SWITCH_DOWN) && handover_done && !any_evt && !cmd_inactive
    |=> (run_q == RS_OPEN_LOOP)) else $error("open loop not resumed");

  reset_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ17]
    (mode_q == MD_ERROR) && cmd_reset && !any_evt
    |=> (mode_q == MD_INACTIVE) && (fault_q == FLT_RESET))
    else $error("reset event did not clear error");

endmodule

// *** testbench/mps_inverter_model.sv ***
// behavioural three-phase inverter and motor seen from the supervisor
`timescale 1ns/10ps

// ==========================================================================
// inverter model
module mps_inverter_model (
  input wire logic [5:0] pwm_oe,
  input wire logic signed [15:0] iu_set,
  input wire logic signed [15:0] iw_set,
  input wire logic signed [15:0] spd_set,
  input wire logic [15:0] bus_set,
  output logic signed [15:0] cur_u,
  output logic signed [15:0] cur_v,
  output logic signed [15:0] cur_w,
  output logic signed [15:0] speed,
  output logic [15:0] volts
);
  // no current flows once the gates float
  assign cur_u = (pwm_oe != 6'h00) ? iu_set : 16'sh0000;
  assign cur_w = (pwm_oe != 6'h00) ? iw_set : 16'sh0000;
  // phase currents sum to zero in a star winding
  assign cur_v = -(cur_u + cur_w);
  // rotor coasts, so the speed reading does not depend on the gates
  assign speed = spd_set;
  assign volts = bus_set;
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench of the mode and protection supervisor
`timescale 1ns/10ps

module tb_top;
  import mps_pkg::*;
  logic clk = 0;
  logic rst_b = 0;
  logic [4:0] ev = 5'h00;
  logic stall_en = 0;
  logic stall_on = 0;
  logic estop_b = 1;
  logic signed [15:0] iu = 0;
  logic signed [15:0] iw = 0;
  logic signed [15:0] spd = 0;
  logic signed [15:0] scmd = 0;
  logic [15:0] bus = 16'h012c;
  logic [5:0] pwm_in = 6'h2a;
  logic [15:0] rated = 16'h19c6;
  logic signed [15:0] cu, cv, cw, sp;
  logic [15:0] bv;
  mps_mode_t mode;
  mps_run_t run;
  logic [5:0] fault, pwm_out, pwm_oe;
  logic obs, hreq;
  int n_fail = 0;
  int compares = 0;

  always #20 clk = ~clk;

  mps_inverter_model INV (.pwm_oe(pwm_oe), .iu_set(iu), .iw_set(iw), .spd_set(spd),
    .bus_set(bus), .cur_u(cu), .cur_v(cv), .cur_w(cw), .speed(sp), .volts(bv));

  // ev bits: 0 start, 1 stop, 2 error release, 3 handover done, 4 control tick
  mps_supervisor DUT (.clk(clk), .rst_b(rst_b), .cmd_active(ev[0]), .cmd_inactive(ev[1]),
    .cmd_reset(ev[2]), .ctrl_tick(ev[4]), .phase_u_ma(cu), .phase_v_ma(cv),
    .phase_w_ma(cw), .rated_motor_current_setting(rated), .bus_volts(bv),
    .speed_rpm(sp), .speed_cmd_rpm(scmd), .handover_done(ev[3]), .stall_enable(stall_en),
    .stall_seen(stall_on), .estop_hw_b(estop_b), .pwm_in(pwm_in), .mode_q(mode),
    .run_q(run), .fault_q(fault), .observer_sel_q(obs), .handover_req_q(hreq),
    .pwm_out_q(pwm_out), .pwm_oe_q(pwm_oe));

  // ==========================================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 5'h00;
    #1;
  endtask

  // bounded wait for a run state
  task automatic wait_run(input mps_run_t r);
    int i;
    // never read the run state in the time step of the edge that updates it
    #1;
    for (i = 0; i < 10 && run !== r; i++) step(1);
    chk(8'(run), 8'(r));
    if (run !== r) final_report();
  endtask

  // case k at its limit (over=0) or one step past it (over=1); k 0 and 1 overcurrent on u and w, k 2 to 5 fault bit k-1
  task automatic setc(input int k, input int over);
    @(posedge clk);
    case (k)
      0: iu <= 16'(9329 + over);
      1: iw <= 16'(-(9329 + over));
      2: bus <= 16'(450 + over);
      3: bus <= 16'(100 - over);
      4: spd <= 16'(-(4200 + over));
      default: begin
        stall_on <= 1;
        stall_en <= over[0];
      end
    endcase
  endtask

  task automatic to_observer();
    if (mode !== MD_ACTIVE) pulse(5'h01);
    @(posedge clk);
    scmd <= 700;
    wait_run(RS_SWITCH_UP);
    pulse(5'h08);
    step(1);
    chk(8'(run), 8'(RS_OBSERVER));
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    chk(8'(mode), 8'(MD_INACTIVE));
    chk(8'(run), 8'(RS_STOP));
    chk(8'(pwm_oe), 8'h00);
    rst_b <= 1;
    pulse(5'h06);
    chk(8'(mode), 8'(MD_INACTIVE));
    @(posedge clk);
    scmd <= 700;
    step(4);
    chk(8'(run), 8'(RS_STOP));
    @(posedge clk);
    scmd <= 0;
    pulse(5'h01);
    chk(8'(mode), 8'(MD_ACTIVE));
    step(1);
    chk(8'(run), 8'(RS_OPEN_LOOP));
    chk(8'(pwm_oe), 8'h3f);
    chk(8'(pwm_out), 8'h2a);
    setc(5, 1);
    pulse(5'h10);
    chk(8'(fault), 8'h00);
    @(posedge clk);
    stall_on <= 0;
    to_observer();
    chk(8'(obs), 8'h01);
    chk(8'(hreq), 8'h00);
    @(posedge clk);
    scmd <= 600;
    wait_run(RS_SWITCH_DOWN);
    chk(8'(hreq), 8'h01);
    pulse(5'h08);
    wait_run(RS_OPEN_LOOP);
    for (int k = 0; k < 6; k++) begin
      to_observer();
      setc(k, 0);
      pulse(5'h10);
      chk(8'(fault), 8'h00);
      setc(k, 1);
      step(2);
      chk(8'(fault), 8'h00);
      pulse(5'h10);
      chk(8'(fault), 8'(6'h01 << ((k == 0) ? 0 : k - 1)));
      chk(8'(mode), 8'(MD_ERROR));
      chk(8'(run), 8'(RS_STOP));
      chk(8'(pwm_oe), 8'h00);
      @(posedge clk);
      iu <= 0;
      iw <= 0;
      bus <= 16'h012c;
      spd <= 0;
      stall_on <= 0;
      pulse(5'h04);
      chk(8'(mode), 8'(MD_INACTIVE));
      chk(8'(fault), 8'h00);
    end
    // a smaller rated setting must pull the trip point down with it
    @(posedge clk);
    rated <= 16'h0100;
    pulse(5'h01);
    @(posedge clk);
    iu <= 16'((256 * OC_SCALE_NUM) >> OC_SCALE_SHIFT);
    pulse(5'h10);
    chk(8'(fault), 8'h00);
    @(posedge clk);
    iu <= 16'(((256 * OC_SCALE_NUM) >> OC_SCALE_SHIFT) + 1);
    pulse(5'h10);
    chk(8'(fault), 8'h01);
    chk(8'(mode), 8'(MD_ERROR));
    @(posedge clk);
    iu <= 0;
    rated <= 16'h19c6;
    pulse(5'h04);
    chk(8'(mode), 8'(MD_INACTIVE));
    to_observer();
    @(posedge clk);
    estop_b <= 0;
    step(4);
    chk(8'(pwm_oe), 8'h00);
    chk(8'(fault), 8'h20);
    pulse(5'h04);
    chk(8'(mode), 8'(MD_ERROR));
    @(posedge clk);
    estop_b <= 1;
    step(3);
    pulse(5'h04);
    chk(8'(mode), 8'(MD_INACTIVE));
    pulse(5'h01);
    chk(8'(mode), 8'(MD_ACTIVE));
    pulse(5'h02);
    chk(8'(mode), 8'(MD_INACTIVE));
    chk(8'(pwm_oe), 8'h00);
    final_report();
  end
endmodule
